// [rtl/storm_block_limiter.sv]
`timescale 1ns/1ns
`include "switch_global_consts.svh"
module storm_block_limiter #(
    parameter int PORTS = 3,
    parameter int PERIOD_100_CYCLES = `STORM_PERIOD_100_CYCLES,
    parameter int PERIOD_10_CYCLES = `STORM_PERIOD_10_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // settings
    input wire logic [`STORM_LIMIT_W-1:0] limit,
    input wire logic [PORTS-1:0] port_is_10,
    // data and verdict
    input wire logic [PORTS-1:0] byte_valid,
    output logic [PORTS-1:0] byte_drop,
    output logic [PORTS-1:0] over_limit
);
    localparam logic [`PERIOD_CNT_W-1:0] P100_LAST =
        `PERIOD_CNT_W'(PERIOD_100_CYCLES - 1);
    localparam logic [`PERIOD_CNT_W-1:0] P10_LAST =
        `PERIOD_CNT_W'(PERIOD_10_CYCLES - 1);

    switch_global_pkg::storm_port_t [PORTS-1:0] st_reg, st_next;
    logic [PORTS-1:0] drop_reg, drop_next, over_reg, over_next;

    // ----------------------------------------------------------------
    // per-port block accounting
    // ----------------------------------------------------------------
    // a block is admitted or refused on its first byte, so a frame is
    // cut inside a block only where a period reload restarts the byte
    // count; partial blocks carry over frames within one period
    always_comb begin
        switch_global_pkg::storm_port_t cur;
        logic ok;
        cur = '0;
        ok = 1'b0;
        st_next = st_reg;
        drop_next = '0;
        over_next = over_reg;
        for (int p = 0; p < PORTS; p++) begin
            cur = st_reg[p];
            if (st_reg[p].period_cnt == '0) begin
                cur.byte_cnt = '0;
                cur.block_cnt = '0;
                cur.block_ok = 1'b0;
                cur.period_cnt = port_is_10[p] ? P10_LAST : P100_LAST;
            end else begin
                cur.period_cnt = st_reg[p].period_cnt - 1'b1;
            end
            if (byte_valid[p]) begin
                if (cur.byte_cnt == '0) begin
                    ok = cur.block_cnt < limit;
                    cur.block_ok = ok;
                    if (ok) begin
                        cur.block_cnt = cur.block_cnt + 1'b1;
                    end
                end else begin
                    ok = cur.block_ok;
                end
                cur.byte_cnt = cur.byte_cnt + 1'b1;
                drop_next[p] = !ok;
            end
            over_next[p] = cur.block_cnt >= limit;
            st_next[p] = cur;
        end
        if (reset) begin
            st_next = '0;
            drop_next = '0;
            over_next = '0;
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        st_reg <= st_next;
        drop_reg <= drop_next;
        over_reg <= over_next;
    end

    assign byte_drop = drop_reg;
    assign over_limit = over_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    for (genvar g = 0; g < PORTS; g++) begin : g_chk
        storm_admit_a: assert property (@(posedge clk) disable iff (reset)
            (byte_valid[g] && st_reg[g].period_cnt != '0 &&
             st_reg[g].byte_cnt == '0 && st_reg[g].block_cnt < limit)
            |=> !byte_drop[g])
            else $error("block under the limit was refused");
        storm_refuse_a: assert property (@(posedge clk) disable iff (reset)
            (byte_valid[g] && st_reg[g].period_cnt != '0 &&
             st_reg[g].byte_cnt == '0 && st_reg[g].block_cnt >= limit)
            |=> byte_drop[g])
            else $error("block over the limit was admitted");
        period_reload_a: assert property (@(posedge clk) disable iff (reset)
            st_reg[g].period_cnt == '0 |=> st_reg[g].period_cnt ==
            ($past(port_is_10[g]) ? P10_LAST : P100_LAST))
            else $error("storm period reloaded with wrong length");
    end
endmodule

// [rtl/switch_global_consts.svh]
`ifndef SWITCH_GLOBAL_CONSTS_SVH
`define SWITCH_GLOBAL_CONSTS_SVH
// Behaviour
// - Bit 5 of the mii/storm register enables switch mii flow control, reset from the rx data 3 strap.
// - Bit 4 of the mii/storm register selects 10 Mbps (1) or 100 Mbps (0), reset from the rx data 1 strap.
// - When the null-vid bit is set, a zero vlan id is replaced by the port default id; it resets to 0.
// - The 11-bit storm limit takes bits 10..8 from bits 2..0 (reset 000) and bits 7..0 from the next register.
// - Each input port counts data in 64-byte blocks and admits no more blocks per period than the limit.
// - The storm measurement period is 67 ms at 100 Mbps and 500 ms at 10 Mbps.
// - The low byte of the storm limit resets to 0x63.
// - Bit 7 of the led register is the upper led mode bit, loaded from its strap while reset is high.
// - The upper led mode bit and bit 1 of the same register form a two-bit led mode code.

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_MII_STORM 8'h06
`define ADDR_STORM_LOW 8'h07
`define ADDR_FACTORY_A 8'h08
`define ADDR_FACTORY_B 8'h09
`define ADDR_FACTORY_C 8'h0a
`define ADDR_LED_CTRL 8'h0b

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FLOW_CTRL_BIT 5
`define SPEED_10_BIT 4
`define NULL_VID_BIT 3
`define STORM_HI_MSB 2
`define LED_UPPER_BIT 7
`define LED_LOWER_BIT 1
`define MII_CTRL_RESET 8'h00
`define STORM_LOW_RESET 8'h63
`define FACTORY_A_RESET 8'h00
`define FACTORY_B_RESET 8'h24
`define FACTORY_C_RESET 8'h35
`define LED_CTRL_RESET 8'h08
`define NULL_VID 12'h000

// ----------------------------------------------------------------
// storm timing
// ----------------------------------------------------------------
`define BLOCK_BYTES 64
`define CLK_PERIOD_NS 10
`define STORM_PERIOD_100_MS 67
`define STORM_PERIOD_10_MS 500
`define STORM_PERIOD_100_CYCLES \
    (`STORM_PERIOD_100_MS * 1000000 / `CLK_PERIOD_NS)
`define STORM_PERIOD_10_CYCLES \
    (`STORM_PERIOD_10_MS * 1000000 / `CLK_PERIOD_NS)
`define PERIOD_CNT_W 26
`define STORM_LIMIT_W 11
`endif

// [rtl/switch_global_control_bank.sv]
`timescale 1ns/1ns
`include "switch_global_consts.svh"
module switch_global_control_bank #(
    parameter int PORTS = 3,
    parameter int PERIOD_100_CYCLES = `STORM_PERIOD_100_CYCLES,
    parameter int PERIOD_10_CYCLES = `STORM_PERIOD_10_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // strap pins, sampled while reset is high
    input wire logic switch_rx_data3_strap,
    input wire logic switch_rx_data1_strap,
    input wire logic led_mode_upper_bit,
    input wire logic led_mode_lower_bit,
    // management register access
    input wire switch_global_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // settings to the switch core
    output logic flow_ctrl_en,
    output logic mii_speed_10,
    output logic null_vid_replace_en,
    output logic [`STORM_LIMIT_W-1:0] storm_limit,
    output logic [1:0] led_mode,
    // vlan id substitution
    input wire logic vid_valid,
    input wire logic [11:0] vid_in,
    input wire logic [11:0] port_vid,
    output logic [11:0] vid_out,
    output logic vid_out_valid,
    // storm protection, last port is the switch mii port
    input wire logic [PORTS-2:0] phy_speed_10,
    input wire logic [PORTS-1:0] storm_byte_valid,
    output logic [PORTS-1:0] storm_byte_drop,
    output logic [PORTS-1:0] storm_over_limit
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] mii_reg, mii_next;
    logic [7:0] low_reg, low_next;
    logic [7:0] fta_reg, fta_next;
    logic [7:0] ftb_reg, ftb_next;
    logic [7:0] ftc_reg, ftc_next;
    logic [7:0] led_reg, led_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [11:0] vid_reg, vid_next;
    logic vidv_reg, vidv_next;
    logic [PORTS-1:0] port_is_10;

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    // unmapped offsets read as zero so a stray probe sees no garbage
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input logic [7:0] mii,
        input logic [7:0] low,
        input logic [7:0] fa,
        input logic [7:0] fb,
        input logic [7:0] fc,
        input logic [7:0] led
    );
        logic [7:0] d;
        d = 8'h00;
        case (addr)
            `ADDR_MII_STORM: d = mii;
            `ADDR_STORM_LOW: d = low;
            `ADDR_FACTORY_A: d = fa;
            `ADDR_FACTORY_B: d = fb;
            `ADDR_FACTORY_C: d = fc;
            `ADDR_LED_CTRL: d = led;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // ----------------------------------------------------------------
    // register file next state
    // ----------------------------------------------------------------
    // straps are sampled on every edge while reset is high, so the
    // value present at the last reset edge is the one kept
    always_comb begin
        mii_next = mii_reg;
        low_next = low_reg;
        fta_next = fta_reg;
        ftb_next = ftb_reg;
        ftc_next = ftc_reg;
        led_next = led_reg;
        if (reset) begin
            mii_next = `MII_CTRL_RESET;
            mii_next[`FLOW_CTRL_BIT] = switch_rx_data3_strap;
            mii_next[`SPEED_10_BIT] = switch_rx_data1_strap;
            low_next = `STORM_LOW_RESET;
            fta_next = `FACTORY_A_RESET;
            ftb_next = `FACTORY_B_RESET;
            ftc_next = `FACTORY_C_RESET;
            led_next = `LED_CTRL_RESET;
            led_next[`LED_UPPER_BIT] = led_mode_upper_bit;
            led_next[`LED_LOWER_BIT] = led_mode_lower_bit;
        end else if (reg_req.wr) begin
            // factory registers are plain storage; keeping them at
            // their defaults is up to software
            case (reg_req.addr)
                `ADDR_MII_STORM: mii_next = reg_req.wdata;
                `ADDR_STORM_LOW: low_next = reg_req.wdata;
                `ADDR_FACTORY_A: fta_next = reg_req.wdata;
                `ADDR_FACTORY_B: ftb_next = reg_req.wdata;
                `ADDR_FACTORY_C: ftc_next = reg_req.wdata;
                `ADDR_LED_CTRL: led_next = reg_req.wdata;
                default: ;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge clk) begin
        mii_reg <= mii_next;
        low_reg <= low_next;
        fta_reg <= fta_next;
        ftb_reg <= ftb_next;
        ftc_reg <= ftc_next;
        led_reg <= led_next;
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // a read in the same cycle as a write returns the old contents
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (reset) begin
            rdata_next = 8'h00;
        end else if (reg_req.rd) begin
            rdata_next = read_mux(reg_req.addr, mii_reg, low_reg,
                fta_reg, ftb_reg, ftc_reg, led_reg);
            rvalid_next = 1'b1;
        end
    end

    // read data flops
    always_ff @(posedge clk) begin
        rdata_reg <= rdata_next;
        rvalid_reg <= rvalid_next;
    end

    // ----------------------------------------------------------------
    // null vlan id substitution
    // ----------------------------------------------------------------
    // one cycle of latency; result holds until the next request
    always_comb begin
        vid_next = vid_reg;
        vidv_next = 1'b0;
        if (reset) begin
            vid_next = 12'h000;
        end else if (vid_valid) begin
            vidv_next = 1'b1;
            if (mii_reg[`NULL_VID_BIT] && vid_in == `NULL_VID) begin
                vid_next = port_vid;
            end else begin
                vid_next = vid_in;
            end
        end
    end

    // substitution flops
    always_ff @(posedge clk) begin
        vid_reg <= vid_next;
        vidv_reg <= vidv_next;
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign flow_ctrl_en = mii_reg[`FLOW_CTRL_BIT];
    assign mii_speed_10 = mii_reg[`SPEED_10_BIT];
    assign null_vid_replace_en = mii_reg[`NULL_VID_BIT];
    assign storm_limit = {mii_reg[`STORM_HI_MSB:0], low_reg};
    // two-bit led mode code
    assign led_mode = {led_reg[`LED_UPPER_BIT], led_reg[`LED_LOWER_BIT]};
    assign vid_out = vid_reg;
    assign vid_out_valid = vidv_reg;

    // ----------------------------------------------------------------
    // storm protection
    // ----------------------------------------------------------------
    // the switch mii port follows its own speed bit; phy ports report
    // their negotiated speed from outside
    assign port_is_10 = {mii_reg[`SPEED_10_BIT], phy_speed_10};

    storm_block_limiter #(
        .PORTS(PORTS),
        .PERIOD_100_CYCLES(PERIOD_100_CYCLES),
        .PERIOD_10_CYCLES(PERIOD_10_CYCLES)
    ) u_storm (
        .clk(clk),
        .reset(reset),
        .limit(storm_limit),
        .port_is_10(port_is_10),
        .byte_valid(storm_byte_valid),
        .byte_drop(storm_byte_drop),
        .over_limit(storm_over_limit)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    flow_strap_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |->
        flow_ctrl_en == $past(switch_rx_data3_strap))
        else $error("flow control not loaded from its strap");

    speed_strap_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |->
        mii_speed_10 == $past(switch_rx_data1_strap))
        else $error("mii speed not loaded from its strap");

    null_vid_sub_a: assert property (@(posedge clk) disable iff (reset)
        (vid_valid && null_vid_replace_en && vid_in == `NULL_VID)
        |=> vid_out_valid && vid_out == $past(port_vid))
        else $error("null vlan id was not replaced");

    vid_pass_a: assert property (@(posedge clk) disable iff (reset)
        (vid_valid && !null_vid_replace_en) |=> vid_out == $past(vid_in))
        else $error("vlan id changed while replacement is off");

    storm_reset_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> storm_limit == {3'h0, `STORM_LOW_RESET}
        && !null_vid_replace_en)
        else $error("storm limit or null vid bit reset wrong");

    storm_low_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) ##0 !reg_req.wr |=> storm_limit[7:0] == 8'h63)
        else $error("storm limit low byte did not reset to 0x63");

    led_strap_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> led_mode == {$past(led_mode_upper_bit),
        $past(led_mode_lower_bit)})
        else $error("led mode not loaded from its straps");

    led_write_a: assert property (@(posedge clk) disable iff (reset)
        (reg_req.wr && reg_req.addr == `ADDR_LED_CTRL) |=>
        led_mode == {$past(reg_req.wdata[7]), $past(reg_req.wdata[1])})
        else $error("led mode does not follow its register bits");

    readback_a: assert property (@(posedge clk) disable iff (reset)
        (reg_req.wr && !reg_req.rd && reg_req.addr == `ADDR_FACTORY_B)
        ##1 (reg_req.rd && !reg_req.wr &&
        reg_req.addr == `ADDR_FACTORY_B)
        |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 2))
        else $error("register did not read back the last write");

    read_latency_a: assert property (@(posedge clk) disable iff (reset)
        reg_req.rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_req.rd))
        else $error("read valid not a single-cycle answer");

endmodule

// [rtl/switch_global_pkg.sv]
`include "switch_global_consts.svh"
package switch_global_pkg;

    // one management access, read or write
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // per-port storm accounting state
    typedef struct packed {
        logic [`PERIOD_CNT_W-1:0] period_cnt;
        logic [$clog2(`BLOCK_BYTES)-1:0] byte_cnt;
        logic [`STORM_LIMIT_W-1:0] block_cnt;
        logic block_ok;
    } storm_port_t;

endpackage

// [tb/switch_global_control_bank_tb_top.sv]
`timescale 1ns/1ns
`include "switch_global_consts.svh"
module switch_global_control_bank_tb_top;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk;
    logic reset;
    logic strap3, strap1, led_up, led_lo;
    switch_global_pkg::reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid, flow_ctrl_en, mii_speed_10, null_vid_replace_en;
    logic [`STORM_LIMIT_W-1:0] storm_limit;
    logic [1:0] led_mode;
    logic vid_valid, vid_out_valid;
    logic [11:0] vid_in, port_vid, vid_out;
    logic [1:0] phy_speed_10;
    logic [2:0] storm_byte_valid, storm_byte_drop, storm_over_limit;
    logic [2:0] prev, seen;
    int err_total, compares;
    int adm[3], resume[3];
    int per[3] = '{200, 500, 500};
    time t_rel0;

    // small periods keep the storm test short
    switch_global_control_bank #(.PORTS(3), .PERIOD_100_CYCLES(200),
        .PERIOD_10_CYCLES(500)) u_switch_global_control_bank (
        .clk(clk), .reset(reset),
        .switch_rx_data3_strap(strap3), .switch_rx_data1_strap(strap1),
        .led_mode_upper_bit(led_up), .led_mode_lower_bit(led_lo),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .flow_ctrl_en(flow_ctrl_en), .mii_speed_10(mii_speed_10),
        .null_vid_replace_en(null_vid_replace_en),
        .storm_limit(storm_limit), .led_mode(led_mode),
        .vid_valid(vid_valid), .vid_in(vid_in), .port_vid(port_vid),
        .vid_out(vid_out), .vid_out_valid(vid_out_valid),
        .phy_speed_10(phy_speed_10), .storm_byte_valid(storm_byte_valid),
        .storm_byte_drop(storm_byte_drop),
        .storm_over_limit(storm_over_limit));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
            input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // straps flip after release so a late capture would show
    task automatic do_reset(input logic [3:0] s);
        @(posedge clk);
        {strap3, strap1, led_up, led_lo} <= s;
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_rel0 = $time;
        @(posedge clk);
        {strap3, strap1, led_up, led_lo} <= ~s;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk);
        reg_req <= '0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        reg_req <= '0;
        #1;
        check(reg_rvalid, 1'b1, "read strobe");
        check(reg_rdata, exp, "read data");
    endtask

    task automatic vid_check(input logic [11:0] vi, input logic [11:0] pv,
            input logic [11:0] exp);
        @(posedge clk);
        vid_valid <= 1'b1;
        vid_in <= vi;
        port_vid <= pv;
        @(posedge clk);
        vid_valid <= 1'b0;
        #1;
        check(vid_out_valid, 1'b1, "vid strobe");
        check(vid_out, exp, "vid result");
    endtask

    // reset view of every register and derived output
    task automatic check_resets(input logic [3:0] s);
        #1;
        check(flow_ctrl_en, s[3], "flow reset");
        check(mii_speed_10, s[2], "speed reset");
        check(null_vid_replace_en, 1'b0, "null vid reset");
        check(storm_limit, 11'h063, "limit reset");
        check(led_mode, {s[1], s[0]}, "led reset");
        check(storm_over_limit, 3'h0, "over reset");
        reg_read(8'h06, {2'b00, s[3], s[2], 4'h0});
        reg_read(8'h07, 8'h63);
        reg_read(8'h08, 8'h00);
        reg_read(8'h09, 8'h24);
        reg_read(8'h0a, 8'h35);
        reg_read(8'h0b, {s[1], 3'b000, 1'b1, 1'b0, s[0], 1'b0});
    endtask

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // the full run needs about 700 cycles
    initial begin
        #100000;
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        give_verdict();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        {strap3, strap1, led_up, led_lo} = 4'h0;
        reg_req = '0;
        vid_valid = 1'b0;
        vid_in = 12'h000;
        port_vid = 12'h000;
        phy_speed_10 = 2'b10;
        storm_byte_valid = 3'h0;
        prev = 3'h0;
        seen = 3'h0;
        err_total = 0;
        compares = 0;
        for (int p = 0; p < 3; p++) begin
            adm[p] = 0;
            resume[p] = 0;
        end
        do_reset(4'b1010);
        check_resets(4'b1010);
        $display("test strap reset done");

        reg_write(8'h06, 8'h3d);
        reg_write(8'h07, 8'hc4);
        #1;
        check({flow_ctrl_en, mii_speed_10}, 2'b11, "mii bits");
        check(null_vid_replace_en, 1'b1, "null vid bit");
        check(storm_limit, 11'h5c4, "limit split");
        reg_read(8'h06, 8'h3d);
        reg_write(8'h0b, 8'h02);
        #1;
        check(led_mode, 2'b01, "led lower");
        reg_write(8'h0b, 8'h80);
        #1;
        check(led_mode, 2'b10, "led upper");
        reg_read(8'h0b, 8'h80);
        // write then read with no idle cycle, as the readback check wants
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, 8'h09, 8'ha5};
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, 8'h09, 8'h00};
        @(posedge clk);
        reg_req <= '0;
        #1;
        check(reg_rdata, 8'ha5, "read after write");
        reg_read(8'h09, 8'ha5);
        reg_write(8'h09, 8'h24);
        reg_write(8'h20, 8'hff);
        reg_read(8'h20, 8'h00);
        reg_read(8'h07, 8'hc4);
        // read and write together return the old contents
        @(posedge clk);
        reg_req <= '{1'b1, 1'b1, 8'h0a, 8'h77};
        @(posedge clk);
        reg_req <= '0;
        #1;
        check(reg_rdata, 8'h35, "read beside write");
        reg_read(8'h0a, 8'h77);
        reg_write(8'h0a, 8'h35);
        $display("test register access done");

        vid_check(12'h000, 12'h123, 12'h123);
        vid_check(12'h456, 12'h123, 12'h456);
        reg_write(8'h06, 8'h35);
        vid_check(12'h000, 12'h123, 12'h000);
        $display("test vid replacement done");

        // second reset in mid-run with opposite straps
        do_reset(4'b0101);
        check_resets(4'b0101);
        $display("test second reset done");

        // limit of two blocks, all ports loaded every cycle
        reg_write(8'h06, 8'h10);
        reg_write(8'h07, 8'h02);
        for (int i = 0; i < 620; i++) begin
            @(posedge clk);
            storm_byte_valid <= 3'b111;
            #1;
            for (int p = 0; p < 3; p++) begin
                if (prev[p] && storm_byte_drop[p] && !seen[p]) begin
                    seen[p] = 1'b1;
                    check(storm_over_limit[p], 1'b1, "over flag");
                end else if (prev[p] && !seen[p]) begin
                    adm[p]++;
                end else if (prev[p] && !storm_byte_drop[p] &&
                        resume[p] == 0) begin
                    resume[p] = int'(($time - t_rel0) / 10);
                end
            end
            prev = 3'b111;
        end
        @(posedge clk);
        storm_byte_valid <= 3'h0;
        for (int p = 0; p < 3; p++) begin
            check(adm[p], 16'd128, "admitted bytes");
            check(resume[p] >= per[p] - 2 && resume[p] <= per[p] + 6,
                1'b1, "period length");
        end
        $display("test storm limiter done");
        give_verdict();
    end
endmodule
